// [general_purpose_timer_edge_modes_tb_top.sv]
// Self-checking bench for the edge-mode timer
`timescale 1ns/10ps
`include "gpt_consts.vh"
module general_purpose_timer_edge_modes_tb_top;
	logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq;
	logic        dma_req_a, dma_req_b, rerr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdat, dma_cnt_a, dma_cnt_b, nb, na;
	logic [1:0]  fire, pin;
	int          n_mismatch, cmp_count, cyc;
	// Reset values: offset beside expected word
	logic [39:0] rows [12] = '{{`GPT_OFS_CFG, 32'h2}, {`GPT_OFS_MODE, 32'h0},
		{`GPT_OFS_CTL, 32'h0}, {`GPT_OFS_LOAD_A, 32'hffff}, {`GPT_OFS_LOAD_B, 32'hffff},
		{`GPT_OFS_MATCH_B, 32'h0}, {`GPT_OFS_PRE_A, 32'h0}, {`GPT_OFS_CNT_B, 32'hffff},
		{`GPT_OFS_CAP_A, 32'h0}, {`GPT_OFS_ISTS, 32'h0}, {`GPT_OFS_IMASK, 32'h0},
		{8'h3c, 32'h0}};
	gpt_edge_timer #(.PRE_W(8)) u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .capture_compare_pin_a(pin[0]),
		.capture_compare_pin_b(pin[1]), .dma_req_a(dma_req_a), .dma_req_b(dma_req_b),
		.irq(irq));
	gpt_edge_src u_src (.pclk(pclk), .presetn(presetn), .fire(fire), .dma_req_a(dma_req_a),
		.dma_req_b(dma_req_b), .pin(pin), .dma_cnt_a(dma_cnt_a), .dma_cnt_b(dma_cnt_b));
	////////////////////////////////////////
	// Clock at 25 MHz
	initial begin
		pclk = 1'h0;
		forever #20 pclk = ~pclk;
	end
	// Hang guard
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 90000) begin
			n_mismatch++;
			final_report();
		end
	end
	task automatic final_report();
		$display("compares=%0d mismatches=%0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Compare one value
	task automatic ck(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One APB transfer, held until ready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		ck(rdat, e);
	endtask
	// Capture events, one every fourth cycle
	task automatic ev(input logic [1:0] p, input int n);
		repeat (n) begin
			@(posedge pclk);
			fire <= p;
			@(posedge pclk);
			fire <= 2'h0;
			repeat (2) @(posedge pclk);
		end
		repeat (3) @(posedge pclk);
	endtask
	////////////////////////////////////////
	// Main sequence
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, fire} = '0;
		ce = 1'h1;
		repeat (12) @(posedge pclk);
		presetn <= 1'h1;
		foreach (rows[i]) begin
			rc(rows[i][39:32], rows[i][31:0]);
			ck(32'(rerr), 32'(rows[i][39:32] == 8'h3c));
		end
		$display("test reset values done");
		// Flawed split edge count on A
		wr(`GPT_OFS_IMASK, 32'hf);
		wr(`GPT_OFS_LOAD_A, 32'h5);
		wr(`GPT_OFS_MATCH_A, 32'h3);
		wr(`GPT_OFS_CTL, 32'h3);
		ev(2'h1, 2);
		rc(`GPT_OFS_CNT_A, 32'h3);
		ck(32'(irq), 32'h1);
		ck(dma_cnt_a, 32'h1);
		ce <= 1'h0;
		repeat (3) @(posedge pclk);
		ce <= 1'h1;
		ev(2'h1, 1);
		rc(`GPT_OFS_CNT_A, 32'h2);
		wr(`GPT_OFS_CTL, 32'h0);
		rc(`GPT_OFS_CNT_A, 32'h1);
		wr(`GPT_OFS_LOAD_A, 32'h2);
		wr(`GPT_OFS_CTL, 32'h1);
		rc(`GPT_OFS_CNT_A, 32'h2);
		wr(`GPT_OFS_MATCH_A, 32'h9);
		rc(`GPT_OFS_CNT_A, 32'h1);
		wr(`GPT_OFS_PRE_A, 32'h0);
		rc(`GPT_OFS_CNT_A, 32'h0);
		wr(`GPT_OFS_ISTS, 32'hf);
		@(negedge pclk);
		ck(32'(irq), 32'h0);
		$display("test flawed split done");
		// Corrected behaviour
		wr(`GPT_OFS_CFG, 32'h0);
		wr(`GPT_OFS_LOAD_A, 32'h4);
		wr(`GPT_OFS_MATCH_A, 32'h2);
		ev(2'h1, 2);
		rc(`GPT_OFS_CNT_A, 32'h4);
		ck(32'(irq), 32'h1);
		wr(`GPT_OFS_MATCH_A, 32'h7);
		rc(`GPT_OFS_CNT_A, 32'h4);
		wr(`GPT_OFS_CTL, 32'h0);
		rc(`GPT_OFS_CNT_A, 32'h4);
		$display("test corrected done");
		// Joined mode, upper halves differ
		wr(`GPT_OFS_CFG, 32'h3);
		wr(`GPT_OFS_ISTS, 32'hf);
		wr(`GPT_OFS_LOAD_B, 32'h1);
		wr(`GPT_OFS_LOAD_A, 32'h3);
		wr(`GPT_OFS_MATCH_B, 32'h5);
		wr(`GPT_OFS_MATCH_A, 32'h2);
		wr(`GPT_OFS_CTL, 32'h1);
		ev(2'h1, 1);
		rc(`GPT_OFS_CNT_A, 32'h00010002);
		rc(`GPT_OFS_ISTS, 32'h1);
		wr(`GPT_OFS_CFG, 32'h1);
		wr(`GPT_OFS_ISTS, 32'hf);
		wr(`GPT_OFS_LOAD_A, 32'h3);
		ev(2'h1, 1);
		rc(`GPT_OFS_ISTS, 32'h0);
		$display("test joined done");
		// Revision without timer A edge DMA
		wr(`GPT_OFS_CTL, 32'h0);
		wr(`GPT_OFS_CFG, 32'h6);
		wr(`GPT_OFS_LOAD_A, 32'h3);
		wr(`GPT_OFS_LOAD_B, 32'h3);
		wr(`GPT_OFS_MATCH_B, 32'h2);
		wr(`GPT_OFS_CTL, 32'h303);
		nb = dma_cnt_a;
		ev(2'h3, 1);
		ck(dma_cnt_a, nb);
		ck(dma_cnt_b, 32'h1);
		rc(`GPT_OFS_ISTS, 32'h3);
		$display("test dma loss done");
		// Edge time: rollover request on B, A's request switched off across its wrap
		wr(`GPT_OFS_CFG, 32'h2);
		wr(`GPT_OFS_CTL, 32'h301);
		wr(`GPT_OFS_MODE, 32'h5);
		wr(`GPT_OFS_ISTS, 32'hf);
		ev(2'h2, 1);
		rc(`GPT_OFS_ISTS, 32'h8);
		nb = dma_cnt_b;
		na = dma_cnt_a;
		for (int k = 0; k < 70000 && dma_cnt_b == nb; k++) @(posedge pclk);
		ck(dma_cnt_b, nb + 32'h1);
		wr(`GPT_OFS_CTL, 32'h303);
		ck(dma_cnt_a, na);
		$display("test rollover done");
		// Up-counting clock mode: match write steps the count up
		wr(`GPT_OFS_CTL, 32'h0);
		wr(`GPT_OFS_MODE, 32'h2);
		wr(`GPT_OFS_PRE_A, 32'hff);
		wr(`GPT_OFS_LOAD_A, 32'h10);
		wr(`GPT_OFS_CTL, 32'h1);
		wr(`GPT_OFS_MATCH_A, 32'h40);
		rc(`GPT_OFS_CNT_A, 32'h12);
		// Periodic mode: wrap at zero sets match status
		wr(`GPT_OFS_CTL, 32'h0);
		wr(`GPT_OFS_MODE, 32'h3);
		wr(`GPT_OFS_PRE_A, 32'h0);
		wr(`GPT_OFS_LOAD_A, 32'h2);
		wr(`GPT_OFS_ISTS, 32'hf);
		wr(`GPT_OFS_CTL, 32'h1);
		repeat (320) @(posedge pclk);
		rc(`GPT_OFS_ISTS, 32'h1);
		wr(`GPT_OFS_CTL, 32'h0);
		wr(`GPT_OFS_IMASK, 32'h0);
		@(negedge pclk);
		ck(32'(irq), 32'h0);
		$display("test clocked modes done");
		final_report();
	end
endmodule

// [gpt_chk_sva.sv]
// Port-level assertions for the edge-mode timer
`timescale 1ns/10ps
module gpt_chk (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        ce,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        capture_compare_pin_a,
	input wire logic        capture_compare_pin_b,
	input wire logic        dma_req_a,
	input wire logic        dma_req_b,
	input wire logic        irq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////
	// Zero-wait answer when enable stays high
	AST_APB_NOWAIT: assert property (psel && !penable && ce ##1 psel && penable && ce |-> pready)
		else $error("pready late");
	// Ready only inside an enabled access phase
	AST_RDY_PHASE: assert property (pready |-> ce && psel && penable)
		else $error("pready out of phase");
	// Error only alongside ready
	AST_ERR_PHASE: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	// Holes above the map answer with error
	AST_UNMAPPED: assert property (pready && paddr > 8'h38 |-> pslverr)
		else $error("unmapped not refused");
	// Aligned mapped words answer cleanly
	AST_MAPPED: assert property (pready && paddr <= 8'h38 && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("mapped refused");
	// Refused reads return zero
	AST_ERR_RD_ZERO: assert property (pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read not zero");
	// Frozen clock enable holds irq and requests
	AST_FREEZE: assert property (!ce |=> $stable(irq) && $stable(dma_req_a) && $stable(dma_req_b))
		else $error("state moved while frozen");
	// Clearing the whole mask silences irq
	AST_MASK_OFF: assert property (pready && pwrite && paddr == 8'h38 && pwdata[3:0] == 4'h0 |=> !irq)
		else $error("irq with mask clear");
endmodule

bind gpt_edge_timer gpt_chk u_chk (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .capture_compare_pin_a(capture_compare_pin_a),
	.capture_compare_pin_b(capture_compare_pin_b), .dma_req_a(dma_req_a),
	.dma_req_b(dma_req_b), .irq(irq));

// [gpt_consts.vh]
// Register map, field positions, reset values and modes of the edge-mode timer
// Summary of operation
// - Edge modes: events decrement until match, interrupt
// - Flawed silicon: no reload after edge match
// - Flawed silicon: disabling edge-count half drops one
// - Flawed joined mode matches lower sixteen bits only
// - Flawed edge-time rollover raises spurious DMA request
// - Flawed: match/prescale write steps an enabled edge-count or up-counting clock-mode counter once
// - Flawed revision: timer A edge modes lack DMA
`ifndef GPT_CONSTS_VH
`define GPT_CONSTS_VH

// Register byte offsets
`define GPT_OFS_CFG     8'h00
`define GPT_OFS_MODE    8'h04
`define GPT_OFS_CTL     8'h08
`define GPT_OFS_LOAD_A  8'h0c
`define GPT_OFS_LOAD_B  8'h10
`define GPT_OFS_MATCH_A 8'h14
`define GPT_OFS_MATCH_B 8'h18
`define GPT_OFS_PRE_A   8'h1c
`define GPT_OFS_PRE_B   8'h20
`define GPT_OFS_CNT_A   8'h24
`define GPT_OFS_CNT_B   8'h28
`define GPT_OFS_CAP_A   8'h2c
`define GPT_OFS_CAP_B   8'h30
`define GPT_OFS_ISTS    8'h34
`define GPT_OFS_IMASK   8'h38

// Configuration fields
`define GPT_CFG_JOIN    0
`define GPT_CFG_FLAWED  1
`define GPT_CFG_NODMAA  2
`define GPT_CFG_RST     3'h2

// Control fields
`define GPT_CTL_EN_A    0
`define GPT_CTL_DMA_A   1
`define GPT_CTL_EN_B    8
`define GPT_CTL_DMA_B   9

// Half modes
`define GPT_M_ECNT      2'h0
`define GPT_M_ETIME     2'h1
`define GPT_M_RTC       2'h2
`define GPT_M_PER       2'h3

// Status bits
`define GPT_IS_MATCH_A  0
`define GPT_IS_MATCH_B  1
`define GPT_IS_CAP_A    2
`define GPT_IS_CAP_B    3

`endif

// [gpt_edge_src.sv]
// Edge source on the capture pins and DMA request counter
`timescale 1ns/10ps
module gpt_edge_src (
	input  wire logic        pclk,      // System clock
	input  wire logic        presetn,   // Async reset, low
	input  wire logic [1:0]  fire,      // Event request, B and A
	input  wire logic        dma_req_a, // DMA pulse, half A
	input  wire logic        dma_req_b, // DMA pulse, half B
	output logic      [1:0]  pin,       // Capture pins, B and A
	output logic      [31:0] dma_cnt_a, // Requests taken, A
	output logic      [31:0] dma_cnt_b  // Requests taken, B
);
	////////////////////////////////////////
	// One high cycle per request, low between events
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin       <= 2'h0;
			dma_cnt_a <= 32'h0;
			dma_cnt_b <= 32'h0;
		end else begin
			pin       <= fire & ~pin;
			dma_cnt_a <= dma_cnt_a + 32'(dma_req_a);
			dma_cnt_b <= dma_cnt_b + 32'(dma_req_b);
		end
	end
endmodule

// [gpt_edge_timer.v]
// Two-half edge count / edge time timer with APB registers, IRQ and DMA
`timescale 1ns/10ps
`include "gpt_consts.vh"

module gpt_edge_timer #(
	parameter PRE_W = 8
) (
	pclk,
	presetn,
	ce,
	psel,
	penable,
	pwrite,
	paddr,
	pwdata,
	prdata,
	pready,
	pslverr,
	capture_compare_pin_a,
	capture_compare_pin_b,
	dma_req_a,
	dma_req_b,
	irq
);
	input  wire        pclk;                  // System clock
	input  wire        presetn;               // Async reset, low
	input  wire        ce;                    // Clock enable
	input  wire        psel;                  // APB select
	input  wire        penable;               // APB access phase
	input  wire        pwrite;                // APB direction
	input  wire [7:0]  paddr;                 // APB byte address
	input  wire [31:0] pwdata;                // APB write data
	output wire [31:0] prdata;                // APB read data
	output wire        pready;                // APB ready
	output wire        pslverr;               // APB error
	input  wire        capture_compare_pin_a; // Event input, half A
	input  wire        capture_compare_pin_b; // Event input, half B
	output wire        dma_req_a;             // DMA pulse, half A
	output wire        dma_req_b;             // DMA pulse, half B
	output wire        irq;                   // Level interrupt

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Step a count one place in its direction, kept within width
	function [31:0] f_step;
		input [31:0] v;
		input        up;
		input [31:0] msk;
		begin
			f_step = (up ? v + 32'h1 : v - 32'h1) & msk;
		end
	endfunction

	// Modes driven by capture pin events
	function f_edge;
		input [1:0] m;
		begin
			f_edge = (m == `GPT_M_ECNT) || (m == `GPT_M_ETIME);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// State

	reg  [2:0]       cfg_ff;        // Join, flawed, no A DMA
	reg  [3:0]       mode_ff;       // B mode [3:2], A mode [1:0]
	reg  [3:0]       ctl_ff;        // dma_b, en_b, dma_a, en_a
	reg  [15:0]      load_a_ff;     // Interval load, half A
	reg  [15:0]      load_b_ff;     // Interval load, half B
	reg  [15:0]      match_a_ff;    // Match value, half A
	reg  [15:0]      match_b_ff;    // Match value, half B
	reg  [PRE_W-1:0] pre_a_ff;      // Prescale, half A
	reg  [PRE_W-1:0] pre_b_ff;      // Prescale, half B
	reg  [PRE_W-1:0] pc_a_ff;       // Prescale counter, half A
	reg  [PRE_W-1:0] pc_b_ff;       // Prescale counter, half B
	reg  [15:0]      cnt_a_ff;      // Counter, half A
	reg  [15:0]      cnt_b_ff;      // Counter, half B
	reg  [15:0]      stamp_a_ff;    // Free time base, half A
	reg  [15:0]      stamp_b_ff;    // Free time base, half B
	reg  [15:0]      cap_a_ff;      // Captured time, half A
	reg  [15:0]      cap_b_ff;      // Captured time, half B
	reg  [1:0]       pin_ff;        // Previous pin levels
	reg  [3:0]       ists_ff;       // Sticky status
	reg  [3:0]       imask_ff;      // Interrupt mask
	reg              dma_a_ff;      // DMA pulse A
	reg              dma_b_ff;      // DMA pulse B
	reg  [31:0]      prdata_ff;     // Read data
	reg              ok_ff;         // Read data prepared

	////////////////////////////////////////////////////////////////////////
	// Bus decode

	wire        wr      = psel & penable & pwrite & pready;
	wire        joined  = cfg_ff[`GPT_CFG_JOIN];
	wire        flawed  = cfg_ff[`GPT_CFG_FLAWED];
	wire [1:0]  mode_a  = mode_ff[1:0];
	wire [1:0]  mode_b  = mode_ff[3:2];
	wire        en_a    = ctl_ff[0];
	wire        en_b    = ctl_ff[2] & ~joined;
	wire        wr_ctl  = wr & (paddr == `GPT_OFS_CTL);
	wire        wr_ld_a = wr & (paddr == `GPT_OFS_LOAD_A);
	wire        wr_ld_b = wr & (paddr == `GPT_OFS_LOAD_B);
	wire        wr_mp_a = wr & ((paddr == `GPT_OFS_MATCH_A) | (paddr == `GPT_OFS_PRE_A));
	wire        wr_mp_b = wr & ((paddr == `GPT_OFS_MATCH_B) | (paddr == `GPT_OFS_PRE_B));
	wire [3:0]  ctl_wv  = {pwdata[`GPT_CTL_DMA_B], pwdata[`GPT_CTL_EN_B],
		pwdata[`GPT_CTL_DMA_A], pwdata[`GPT_CTL_EN_A]};
	reg  [31:0] rd_mux;             // Read selection
	reg         hit_map;            // Address is mapped

	// Read multiplexer, unmapped reads zero with error
	always @* begin
		hit_map = 1'b1;
		case (paddr)
			`GPT_OFS_CFG:     rd_mux = {29'h0, cfg_ff};
			`GPT_OFS_MODE:    rd_mux = {28'h0, mode_ff};
			`GPT_OFS_CTL:     rd_mux = {22'h0, ctl_ff[3:2], 6'h0, ctl_ff[1:0]};
			`GPT_OFS_LOAD_A:  rd_mux = {16'h0, load_a_ff};
			`GPT_OFS_LOAD_B:  rd_mux = {16'h0, load_b_ff};
			`GPT_OFS_MATCH_A: rd_mux = {16'h0, match_a_ff};
			`GPT_OFS_MATCH_B: rd_mux = {16'h0, match_b_ff};
			`GPT_OFS_PRE_A:   rd_mux = {{(32-PRE_W){1'b0}}, pre_a_ff};
			`GPT_OFS_PRE_B:   rd_mux = {{(32-PRE_W){1'b0}}, pre_b_ff};
			`GPT_OFS_CNT_A:   rd_mux = joined ? {cnt_b_ff, cnt_a_ff} : {16'h0, cnt_a_ff};
			`GPT_OFS_CNT_B:   rd_mux = {16'h0, cnt_b_ff};
			`GPT_OFS_CAP_A:   rd_mux = {16'h0, cap_a_ff};
			`GPT_OFS_CAP_B:   rd_mux = {16'h0, cap_b_ff};
			`GPT_OFS_ISTS:    rd_mux = {28'h0, ists_ff};
			`GPT_OFS_IMASK:   rd_mux = {28'h0, imask_ff};
			default: begin
				rd_mux  = 32'h0;
				hit_map = 1'b0;
			end
		endcase
	end

	// Zero wait states once read data is latched
	assign pready  = ce & ok_ff;
	assign pslverr = psel & penable & pready & ~hit_map;
	assign prdata  = prdata_ff;

	////////////////////////////////////////////////////////////////////////
	// Counter next state

	wire        ev_a   = capture_compare_pin_a & ~pin_ff[0];  // Rising edges
	wire        ev_b   = capture_compare_pin_b & ~pin_ff[1];
	wire [31:0] msk_a  = joined ? 32'hffffffff : 32'h0000ffff;
	wire [31:0] msk_b  = 32'h0000ffff;
	wire [31:0] cur_a  = {joined ? cnt_b_ff : 16'h0, cnt_a_ff};
	wire [31:0] ld_a   = {joined ? load_b_ff : 16'h0, load_a_ff};
	wire [31:0] mt_a   = {joined ? match_b_ff : 16'h0, match_a_ff};
	wire [31:0] cur_b  = {16'h0, cnt_b_ff};
	wire        up_a   = mode_a == `GPT_M_RTC;
	wire        up_b   = mode_b == `GPT_M_RTC;
	wire        tk_a   = en_a & (f_edge(mode_a) ? ev_a : (pc_a_ff == {PRE_W{1'b0}}));
	wire        tk_b   = en_b & (f_edge(mode_b) ? ev_b : (pc_b_ff == {PRE_W{1'b0}}));
	wire [31:0] st_a   = f_step(cur_a, up_a, msk_a);
	wire [31:0] st_b   = f_step(cur_b, up_b, msk_b);
	wire        per_a  = mode_a == `GPT_M_PER;
	wire        per_b  = mode_b == `GPT_M_PER;
	wire        eq_a   = (joined & flawed) ? (st_a[15:0] == mt_a[15:0]) : (st_a == mt_a);
	wire        hit_a  = tk_a & (per_a ? (cur_a == 32'h0) : eq_a);
	wire        hit_b  = tk_b & (per_b ? (cur_b == 32'h0) : (st_b == {16'h0, match_b_ff}));
	reg  [31:0] nxt_a;              // Next count A (or joined)
	reg  [31:0] nxt_b;              // Next count B

	// Count, reload and flawed-silicon side effects
	always @* begin
		nxt_a = cur_a;
		nxt_b = cur_b;
		// Half A / joined counter
		if (wr_ld_a) begin
			nxt_a = {joined ? load_b_ff : 16'h0, pwdata[15:0]};
		end else if (tk_a) begin
			if (per_a & hit_a) begin
				nxt_a = ld_a;
			end else if (f_edge(mode_a) & hit_a) begin
				nxt_a = flawed ? st_a : ld_a;
			end else begin
				nxt_a = st_a;
			end
		end
		if (flawed & en_a & wr_mp_a & (mode_a == `GPT_M_ECNT | up_a)) begin
			nxt_a = f_step(nxt_a, up_a, msk_a);
		end
		if (flawed & ~joined & (mode_a == `GPT_M_ECNT) & en_a & wr_ctl & ~ctl_wv[0]) begin
			nxt_a = f_step(nxt_a, 1'b0, msk_a);
		end
		// Half B counter
		if (wr_ld_b) begin
			nxt_b = {16'h0, pwdata[15:0]};
		end else if (tk_b) begin
			if (hit_b & (per_b | f_edge(mode_b))) begin
				nxt_b = (flawed & ~per_b) ? st_b : {16'h0, load_b_ff};
			end else begin
				nxt_b = st_b;
			end
		end
		if (flawed & en_b & wr_mp_b & (mode_b == `GPT_M_ECNT | up_b)) begin
			nxt_b = f_step(nxt_b, up_b, msk_b);
		end
		if (flawed & (mode_b == `GPT_M_ECNT) & en_b & wr_ctl & ~ctl_wv[2]) begin
			nxt_b = f_step(nxt_b, 1'b0, msk_b);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Events

	wire et_a    = en_a & (mode_a == `GPT_M_ETIME);
	wire et_b    = en_b & (mode_b == `GPT_M_ETIME);
	wire roll_a  = et_a & (stamp_a_ff == 16'h0);          // Time base wraps
	wire roll_b  = et_b & (stamp_b_ff == 16'h0);
	wire nodma_a = flawed & cfg_ff[`GPT_CFG_NODMAA] & f_edge(mode_a);
	wire nxt_dma_a = ctl_ff[1] & ~nodma_a & (hit_a | (flawed & roll_a));
	wire nxt_dma_b = ctl_ff[3] & ~joined & (hit_b | (flawed & roll_b));
	wire [3:0] ev_set = {et_b & ev_b, et_a & ev_a, hit_b, hit_a};
	wire [3:0] ev_clr = (wr & (paddr == `GPT_OFS_ISTS)) ? pwdata[3:0] : 4'h0;

	assign dma_req_a = dma_a_ff;
	assign dma_req_b = dma_b_ff;
	assign irq       = |(ists_ff & imask_ff);

	////////////////////////////////////////////////////////////////////////
	// Registers

	// All state, frozen while ce is low
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_ff     <= `GPT_CFG_RST;
			mode_ff    <= 4'h0;
			ctl_ff     <= 4'h0;
			load_a_ff  <= 16'hffff;
			load_b_ff  <= 16'hffff;
			match_a_ff <= 16'h0;
			match_b_ff <= 16'h0;
			pre_a_ff   <= {PRE_W{1'b0}};
			pre_b_ff   <= {PRE_W{1'b0}};
			pc_a_ff    <= {PRE_W{1'b0}};
			pc_b_ff    <= {PRE_W{1'b0}};
			cnt_a_ff   <= 16'hffff;
			cnt_b_ff   <= 16'hffff;
			stamp_a_ff <= 16'hffff;
			stamp_b_ff <= 16'hffff;
			cap_a_ff   <= 16'h0;
			cap_b_ff   <= 16'h0;
			pin_ff     <= 2'h0;
			ists_ff    <= 4'h0;
			imask_ff   <= 4'h0;
			dma_a_ff   <= 1'b0;
			dma_b_ff   <= 1'b0;
			prdata_ff  <= 32'h0;
			ok_ff      <= 1'b0;
		end else if (ce) begin
			// Bus handshake and read capture
			ok_ff <= psel & ~(penable & pready);
			if (psel & ~penable) begin
				prdata_ff <= rd_mux;
			end
			// Register writes
			if (wr) begin
				case (paddr)
					`GPT_OFS_CFG:     cfg_ff     <= pwdata[2:0];
					`GPT_OFS_MODE:    mode_ff    <= pwdata[3:0];
					`GPT_OFS_CTL:     ctl_ff     <= ctl_wv;
					`GPT_OFS_LOAD_A:  load_a_ff  <= pwdata[15:0];
					`GPT_OFS_LOAD_B:  load_b_ff  <= pwdata[15:0];
					`GPT_OFS_MATCH_A: match_a_ff <= pwdata[15:0];
					`GPT_OFS_MATCH_B: match_b_ff <= pwdata[15:0];
					`GPT_OFS_PRE_A:   pre_a_ff   <= pwdata[PRE_W-1:0];
					`GPT_OFS_PRE_B:   pre_b_ff   <= pwdata[PRE_W-1:0];
					`GPT_OFS_IMASK:   imask_ff   <= pwdata[3:0];
					default: begin
					end
				endcase
			end
			// Prescalers for the clocked modes
			if (en_a & ~f_edge(mode_a)) begin
				pc_a_ff <= (pc_a_ff == {PRE_W{1'b0}}) ? pre_a_ff : pc_a_ff - 1'b1;
			end
			if (en_b & ~f_edge(mode_b)) begin
				pc_b_ff <= (pc_b_ff == {PRE_W{1'b0}}) ? pre_b_ff : pc_b_ff - 1'b1;
			end
			// Counters; joined mode carries A's upper half in B
			cnt_a_ff <= nxt_a[15:0];
			cnt_b_ff <= joined ? nxt_a[31:16] : nxt_b[15:0];
			// Edge time base and captures
			if (et_a) begin
				stamp_a_ff <= stamp_a_ff - 16'h1;
			end
			if (et_b) begin
				stamp_b_ff <= stamp_b_ff - 16'h1;
			end
			if (et_a & ev_a) begin
				cap_a_ff <= stamp_a_ff;
			end
			if (et_b & ev_b) begin
				cap_b_ff <= stamp_b_ff;
			end
			pin_ff <= {capture_compare_pin_b, capture_compare_pin_a};
			// Sticky status, a new event beats its clear
			ists_ff  <= (ists_ff & ~ev_clr) | ev_set;
			dma_a_ff <= nxt_dma_a;
			dma_b_ff <= nxt_dma_b;
		end
	end

endmodule
